// file: src/gpio_pwm_command_port.sv
// Purpose: Thirteen-pin GPIO/LED port driven by command packets
// Assumes: packets arrive decoded, one per cmd_valid pulse
// Notes: pin inputs are synchronised before sampling
`timescale 1ns/10ps
`default_nettype none

module gpio_pwm_command_port
  import gpio_pwm_pkg::*;
#(
  parameter int STEP_CYCLES = gpio_pwm_pkg::PWM_STEP_CYCLES,
  parameter int SAMPLE_PERIOD = gpio_pwm_pkg::SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire gpio_pwm_pkg::cmd_t cmd,
  output var gpio_pwm_pkg::reply_t reply,
  output logic reply_valid,
  input wire logic [gpio_pwm_pkg::NUM_GPIO-1:0] gpio_in,
  output var gpio_pwm_pkg::pad_t [gpio_pwm_pkg::NUM_GPIO-1:0] gpio_pad,
  output var gpio_pwm_pkg::pad_t [7:0] output_only_pin,
  input wire logic [gpio_pwm_pkg::NUM_GPIO-1:0] default_level,
  output logic [gpio_pwm_pkg::NUM_GPIO-1:0] default_sensed,
  output logic host_power_sensed,
  output logic one_wire_sensor_line,
  input wire logic boot_restore,
  input wire gpio_pwm_pkg::boot_t boot_image_in,
  output var gpio_pwm_pkg::boot_t boot_image,
  output logic boot_store
);
  import gpio_pwm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_GPIO-1:0] sync1;
    logic [NUM_GPIO-1:0] sync2;
    logic [NUM_GPIO-1:0] sampled;
    logic [NUM_GPIO-1:0] rise;
    logic [NUM_GPIO-1:0] fall;
    logic [23:0] step_cnt;
    logic [6:0] phase;
    logic [23:0] sample_cnt;
    boot_t pins;
    pad_t [NUM_PINS-1:0] pad;
    reply_t reply;
    logic reply_valid;
    boot_t image;
    logic store;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // Decoding helpers
  function automatic logic pin_ok(input logic [7:0] idx);
    pin_ok = (idx <= LAST_PIN);
  endfunction

  function automatic logic is_gpio(input logic [7:0] idx);
    is_gpio = (idx < 8'(NUM_GPIO));
  endfunction

  // Maps drive mode and wanted level onto pad controls
  function automatic pad_t drive(input logic [2:0] mode,
                                 input logic lvl);
    pad_t p;
    p = '0;
    p.out = lvl;
    // Pulls act only where the mode leaves a level undriven
    unique case (mode)
      DM_UP_PULLDN: begin
        p.oe = lvl;
        p.pull_dn = !lvl;
      end
      DM_STRONG: p.oe = 1'b1;
      DM_HIZ: p.oe = 1'b0;
      DM_PULLUP_DN: begin
        p.oe = !lvl;
        p.pull_up = lvl;
      end
      DM_SLOW_UP: begin
        p.oe = lvl;
        p.slow = 1'b1;
      end
      DM_SLOW_BOTH: begin
        p.oe = 1'b1;
        p.slow = 1'b1;
      end
      DM_HIZ_SLOWDN: begin
        p.oe = !lvl;
        p.slow = 1'b1;
      end
      // Reserved 110 is never sent; float the pin to be safe
      default: p.oe = 1'b0;
    endcase
    drive = p;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] idx;
    logic [3:0] idx4;
    logic [2:0] gpio_idx;
    logic [NUM_PINS-1:0] owner_lvl;
    logic step_tick;
    logic sample_tick;
    logic set_ok;
    logic read_ok;
    logic lvl;
    logic [NUM_GPIO-1:0] clr;
    idx = cmd.d0;
    idx4 = cmd.d0[3:0];
    gpio_idx = cmd.d0[2:0];
    owner_lvl = NUM_PINS'(default_level);
    step_tick = 1'b0;
    sample_tick = 1'b0;
    set_ok = 1'b0;
    read_ok = 1'b0;
    lvl = 1'b0;
    clr = '0;
    next_st = st;
    next_st.reply_valid = 1'b0;
    next_st.store = 1'b0;

    // Input synchroniser; only sync2 feeds logic
    next_st.sync1 = gpio_in;
    next_st.sync2 = st.sync1;

    // PWM step timer; 100 steps make one 10 ms period
    if (st.step_cnt == 24'(STEP_CYCLES - 1)) begin
      next_st.step_cnt = '0;
      step_tick = 1'b1;
    end else begin
      next_st.step_cnt = st.step_cnt + 24'h000001;
    end
    if (step_tick) begin
      if (st.phase == 7'(PWM_STEPS - 1)) begin
        next_st.phase = '0;
      end else begin
        next_st.phase = st.phase + 7'h01;
      end
    end

    // Slow sampling doubles as the debounce filter
    // Free-running sampler, never aligned to queries
    if (st.sample_cnt == 24'(SAMPLE_PERIOD - 1)) begin
      next_st.sample_cnt = '0;
      sample_tick = 1'b1;
    end else begin
      next_st.sample_cnt = st.sample_cnt + 24'h000001;
    end

    // ==========================================================
    // Command decode; refused packets give no reply, change nothing
    if (cmd_valid) begin
      unique case (cmd.code)
        CMD_SET_PIN: begin
          set_ok = pin_ok(idx) && cmd.d1 <= 8'(LEVEL_HIGH)
                   && (cmd.len == LEN_VALUE
                       || cmd.len == LEN_CONFIG);
          if (set_ok) begin
            next_st.pins.level[idx4] = cmd.d1[6:0];
            if (cmd.len == LEN_CONFIG) begin
              next_st.pins.cfg[idx4] = {
                cmd.d2[CFG_FUNC_BIT] & is_gpio(idx),
                cmd.d2[2:0]};
            end
            next_st.reply = '0;
            next_st.reply.code = CMD_SET_PIN | REPLY_FLAG;
            next_st.reply.len = LEN_ZERO;
            next_st.reply_valid = 1'b1;
          end
        end
        CMD_READ_PIN: begin
          read_ok = pin_ok(idx) && cmd.len == LEN_QUERY;
          if (read_ok) begin
            next_st.reply.code = CMD_READ_PIN | REPLY_FLAG;
            next_st.reply.len = LEN_REPLY;
            next_st.reply.d0 = idx;
            next_st.reply.d1 = '0;
            if (is_gpio(idx)) begin
              next_st.reply.d1[STATE_LEVEL_BIT] =
                st.sampled[gpio_idx];
              next_st.reply.d1[STATE_FALL_BIT] = st.fall[gpio_idx];
              next_st.reply.d1[STATE_RISE_BIT] = st.rise[gpio_idx];
              // Flags leave in this reply and clear behind it
              clr[gpio_idx] = 1'b1;
            end
            next_st.reply.d2 = {1'b0, st.pins.level[idx4]};
            next_st.reply.d3 = {4'h0, st.pins.cfg[idx4]};
            next_st.reply_valid = 1'b1;
          end
        end
        CMD_STORE_BOOT: begin
          next_st.image = st.pins;
          next_st.store = 1'b1;
          next_st.reply = '0;
          next_st.reply.code = CMD_STORE_BOOT | REPLY_FLAG;
          next_st.reply.len = LEN_ZERO;
          next_st.reply_valid = 1'b1;
        end
        default: ;
      endcase
    end

    // Saved image reloaded once the store is read back at power-up
    if (boot_restore) begin
      next_st.pins = boot_image_in;
      // A stale image must not hand LED pins a function flag
      for (int i = NUM_GPIO; i < NUM_PINS; i++) begin
        next_st.pins.cfg[i][CFG_FUNC_BIT] = 1'b0;
      end
    end

    // ==========================================================
    // Sampling and edge latches; a new edge beats a clear
    if (sample_tick) begin
      next_st.sampled = st.sync2;
    end
    for (int i = 0; i < NUM_GPIO; i++) begin
      next_st.rise[i] = (st.rise[i] & !clr[i])
        | (sample_tick & st.sync2[i] & !st.sampled[i]);
      next_st.fall[i] = (st.fall[i] & !clr[i])
        | (sample_tick & !st.sync2[i] & st.sampled[i]);
    end

    // ==========================================================
    // Pad drive; duty compares against the step phase
    for (int i = 0; i < NUM_PINS; i++) begin
      if (st.pins.level[i] >= LEVEL_HIGH) begin
        lvl = 1'b1;
      end else begin
        lvl = st.phase < st.pins.level[i];
      end
      // Default owner supplies level, drive mode still applies
      if (i < NUM_GPIO && !st.pins.cfg[i][CFG_FUNC_BIT]) begin
        lvl = owner_lvl[i];
      end
      next_st.pad[i] = drive(st.pins.cfg[i][2:0], lvl);
    end
  end

  // ==========================================================
  // Registers
  // Only pin configs reset to non-zero; levels and all else start cleared
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.pins.cfg <= CFG_RESET;
      st.pins.level <= {NUM_PINS{LEVEL_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  always_comb begin
    reply = st.reply;
    reply_valid = st.reply_valid;
    boot_image = st.image;
    boot_store = st.store;
    default_sensed = st.sampled;
    host_power_sensed = st.sampled[1];
    one_wire_sensor_line = st.sampled[4];
    for (int i = 0; i < NUM_GPIO; i++) begin
      gpio_pad[i] = st.pad[i];
    end
    // LED pads sit above the GPIO pads in the pad array
    for (int i = 0; i < 8; i++) begin
      output_only_pin[i] = st.pad[i + NUM_GPIO];
    end
  end

endmodule // gpio_pwm_command_port

`default_nettype wire

// file: src/gpio_pwm_pkg.sv
// Purpose: Shared constants and carriers for the GPIO/PWM command port
// Assumes: 100 MHz reference clock
// Notes: Command and reply packets travel as packed structs
`default_nettype none
package gpio_pwm_pkg;

  // ==========================================================
  // Pin counts and command codes
  localparam int NUM_GPIO = 5;
  localparam int NUM_PINS = 13;
  localparam logic [7:0] LAST_PIN = 8'h0C;
  localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
  localparam logic [7:0] CMD_SET_PIN = 8'h22;
  localparam logic [7:0] CMD_READ_PIN = 8'h23;
  localparam logic [7:0] REPLY_FLAG = 8'h40;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_QUERY = 8'h01;
  localparam logic [7:0] LEN_VALUE = 8'h02;
  localparam logic [7:0] LEN_CONFIG = 8'h03;
  localparam logic [7:0] LEN_REPLY = 8'h04;
  localparam logic [6:0] LEVEL_HIGH = 7'h64;

  // ==========================================================
  // Field positions
  localparam int CFG_FUNC_BIT = 3;
  localparam int STATE_LEVEL_BIT = 0;
  localparam int STATE_FALL_BIT = 1;
  localparam int STATE_RISE_BIT = 2;

  // ==========================================================
  // Drive mode codes
  localparam logic [2:0] DM_UP_PULLDN = 3'h0;
  localparam logic [2:0] DM_STRONG = 3'h1;
  localparam logic [2:0] DM_HIZ = 3'h2;
  localparam logic [2:0] DM_PULLUP_DN = 3'h3;
  localparam logic [2:0] DM_SLOW_UP = 3'h4;
  localparam logic [2:0] DM_SLOW_BOTH = 3'h5;
  localparam logic [2:0] DM_HIZ_SLOWDN = 3'h7;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int SAMPLE_HZ = 32;
  localparam int PWM_STEP_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

  // ==========================================================
  // Reset values: factory defaults for ATX and one-wire use
  localparam logic [NUM_PINS-1:0][3:0] CFG_RESET = {
    {8{4'h1}}, 4'h3, 4'h2, 4'h2, 4'h3, 4'h2};
  localparam logic [6:0] LEVEL_RESET = 7'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
  } cmd_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
  } reply_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pull_up;
    logic pull_dn;
    logic slow;
  } pad_t;

  typedef struct packed {
    logic [NUM_PINS-1:0][6:0] level;
    logic [NUM_PINS-1:0][3:0] cfg;
  } boot_t;

endpackage

`default_nettype wire

// file: test/gpio_pwm_command_port_properties.sv
// Purpose: Port checks of the command port
// Assumes: one clock, async reset
// Notes: bound below
`timescale 1ns/10ps
`default_nettype none
module gpio_pwm_command_port_properties
  import gpio_pwm_pkg::*;
#(
  parameter int STEP_CYCLES = gpio_pwm_pkg::PWM_STEP_CYCLES,
  parameter int SAMPLE_PERIOD = gpio_pwm_pkg::SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire gpio_pwm_pkg::cmd_t cmd,
  input wire gpio_pwm_pkg::reply_t reply,
  input wire logic reply_valid,
  input wire logic [gpio_pwm_pkg::NUM_GPIO-1:0] default_sensed,
  input wire logic host_power_sensed,
  input wire logic one_wire_sensor_line,
  input wire logic boot_store
);
  // ==========================================================
  // Helpers
  logic set_ok;
  logic rd_ok;
  int unsigned quiet;
  assign set_ok = cmd_valid && cmd.code == CMD_SET_PIN && cmd.d0 <= LAST_PIN
    && cmd.d1 <= 8'h64 && (cmd.len == LEN_VALUE || cmd.len == LEN_CONFIG);
  assign rd_ok = cmd_valid && cmd.code == CMD_READ_PIN
    && cmd.d0 <= LAST_PIN && cmd.len == LEN_QUERY;
  // Cycles since the sampled levels last moved
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet <= 0;
    end else begin
      quiet <= $changed(default_sensed) ? 0 : quiet + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Assertions
  chk_set_ack: assert property (
    set_ok |=> reply_valid && reply.code == 8'h62 && reply.len == LEN_ZERO)
    else $error("set ack wrong");
  chk_read_reply: assert property (
    rd_ok |=> reply_valid && reply.code == 8'h63 && reply.len == LEN_REPLY
      && reply.d0 == $past(cmd.d0)) else $error("read reply wrong");
  chk_bad_index: assert property (
    cmd_valid && cmd.code[7:1] == 7'h11 && cmd.d0 > LAST_PIN
      |=> !reply_valid) else $error("bad index answered");
  chk_bad_value: assert property (
    cmd_valid && cmd.code == CMD_SET_PIN && cmd.d1 > 8'h64
      |=> !reply_valid) else $error("bad value answered");
  chk_led_zero: assert property (
    reply_valid && reply.code == 8'h63 && reply.d0 > 8'h04
      |-> reply.d1 == 8'h00 && reply.d3[7:3] == 5'h00)
    else $error("output pin state not zero");
  chk_reply_cause: assert property (
    reply_valid |-> $past(cmd_valid)) else $error("reply without cmd");
  chk_sense_map: assert property (
    host_power_sensed == default_sensed[1]
      && one_wire_sensor_line == default_sensed[4])
    else $error("default sense mapping wrong");
  chk_sample_rate: assert property (
    $changed(default_sensed) |-> quiet >= SAMPLE_PERIOD - 2)
    else $error("sample too early");
  chk_store_ack: assert property (
    cmd_valid && cmd.code == CMD_STORE_BOOT && cmd.len == LEN_ZERO
      |=> boot_store && reply_valid && reply.code == 8'h44)
    else $error("store ack wrong");
  cov_set: cover property (set_ok);
  cov_read: cover property (rd_ok);
  cov_store: cover property (boot_store);
  cov_edge: cover property (reply_valid && reply.code == 8'h63 && reply.d1[2]);
endmodule // gpio_pwm_command_port_properties
bind gpio_pwm_command_port gpio_pwm_command_port_properties #(
  .STEP_CYCLES(STEP_CYCLES), .SAMPLE_PERIOD(SAMPLE_PERIOD)
) props (.ref_clk, .reset_n, .cmd_valid, .cmd, .reply, .reply_valid,
  .default_sensed, .host_power_sensed, .one_wire_sensor_line, .boot_store);
`default_nettype wire

// file: test/gpio_pwm_command_port_test.sv
// Purpose: Command sequences against the port
// Assumes: short PWM step and sample period
// Notes: host_model drives commands
`timescale 1ns/10ps
`default_nettype none
module gpio_pwm_command_port_test;
  import gpio_pwm_pkg::*;
  localparam int STEP = 2;
  localparam int PER = 20;
  logic ref_clk, reset_n, cmd_valid, reply_valid, got;
  logic boot_restore, boot_store, host_power_sensed, one_wire_sensor_line;
  logic [NUM_GPIO-1:0] gpio_in, default_level, default_sensed;
  cmd_t cmd;
  reply_t reply, r;
  pad_t [NUM_GPIO-1:0] gpio_pad;
  pad_t [7:0] output_only_pin;
  boot_t boot_image_in, boot_image, b;
  int error_cnt, n_compared, hi;
  logic [2:0] dm [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [7:0] duty [3] = '{8'h00, 8'h32, 8'h64};
  // Pad of a user pin at level 0, per drive mode above
  logic [4:0] pad_lo [7] = '{5'h02, 5'h10, 5'h00, 5'h10, 5'h01, 5'h11, 5'h11};
  gpio_pwm_command_port #(.STEP_CYCLES(STEP), .SAMPLE_PERIOD(PER)) uut (
    .ref_clk, .reset_n, .cmd_valid, .cmd, .reply, .reply_valid, .gpio_in,
    .gpio_pad, .output_only_pin, .default_level, .default_sensed,
    .host_power_sensed, .one_wire_sensor_line, .boot_restore,
    .boot_image_in, .boot_image, .boot_store);
  host_model host (.ref_clk, .cmd_valid, .cmd, .reply, .reply_valid);
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // Tasks
  task automatic cmp(input string what, input logic [7:0] exp, seen);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] code, len, d0, d1, d2,
                      input logic ack);
    host.xfer('{code, len, d0, d1, d2}, got, r);
    cmp("reply present", {7'h0, ack}, {7'h0, got});
  endtask
  task automatic read_pin(input logic [7:0] idx, st, lvl, cf);
    send(CMD_READ_PIN, LEN_QUERY, idx, 8'h00, 8'h00, 1'b1);
    cmp("state", st, r.d1);
    cmp("level", lvl, r.d2);
    cmp("config", cf, r.d3);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    test_done();
  end
  // ==========================================================
  // Sequence
  initial begin
    ref_clk = 0;
    reset_n = 0;
    gpio_in = '0;
    default_level = 5'h15;
    boot_restore = 0;
    boot_image_in = '0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      read_pin(i[7:0], 8'h00, 8'h00, {4'h0, CFG_RESET[i]});
    end
    cmp("default pad", 8'h0C, {3'h0, gpio_pad[4]});
    $display("reset defaults done");
    for (int i = 0; i < 7; i++) begin
      send(CMD_SET_PIN, LEN_CONFIG, 8'h02, 8'h00, {5'h1, dm[i]}, 1'b1);
      read_pin(8'h02, 8'h00, 8'h00, {5'h1, dm[i]});
      cmp("gpio pad", {3'h0, pad_lo[i]}, {3'h0, gpio_pad[2]});
    end
    send(CMD_SET_PIN, LEN_CONFIG, 8'h01, 8'h00, 8'h03, 1'b1);
    $display("drive modes done");
    send(CMD_SET_PIN, LEN_CONFIG, 8'h00, 8'h64, 8'h09, 1'b1);
    send(CMD_SET_PIN, LEN_VALUE, 8'h00, 8'h28, 8'h02, 1'b1);
    read_pin(8'h00, 8'h00, 8'h28, 8'h09);
    send(CMD_SET_PIN, LEN_CONFIG, 8'h07, 8'h64, 8'h0D, 1'b1);
    read_pin(8'h07, 8'h00, 8'h64, 8'h05);
    cmp("led pad", 8'h19, {3'h0, output_only_pin[2]});
    send(CMD_SET_PIN, LEN_VALUE, 8'h0D, 8'h00, 8'h00, 1'b0);
    send(CMD_SET_PIN, LEN_VALUE, 8'h00, 8'h65, 8'h00, 1'b0);
    send(CMD_SET_PIN, LEN_VALUE, 8'h00, 8'hFF, 8'h00, 1'b0);
    send(CMD_READ_PIN, LEN_QUERY, 8'h0D, 8'h00, 8'h00, 1'b0);
    read_pin(8'h00, 8'h00, 8'h28, 8'h09);
    $display("value and refusal done");
    foreach (duty[i]) begin
      send(CMD_SET_PIN, LEN_VALUE, 8'h05, duty[i], 8'h00, 1'b1);
      repeat (100 * STEP) @(posedge ref_clk);
      hi = 0;
      for (int k = 0; k < 100 * STEP; k++) begin
        @(posedge ref_clk);
        hi += output_only_pin[0].out;
      end
      cmp("pwm high cycles", 8'(duty[i] * STEP), hi[7:0]);
    end
    $display("pwm done");
    send(CMD_SET_PIN, LEN_CONFIG, 8'h00, 8'h00, 8'h0A, 1'b1);
    @(posedge ref_clk);
    gpio_in <= 5'h13;
    repeat (PER + 5) @(posedge ref_clk);
    cmp("sensed", 8'h13, {3'h0, default_sensed});
    cmp("power sense", 8'h01, {7'h0, host_power_sensed});
    cmp("one wire", 8'h01, {7'h0, one_wire_sensor_line});
    read_pin(8'h00, 8'h05, 8'h00, 8'h0A);
    read_pin(8'h00, 8'h01, 8'h00, 8'h0A);
    @(posedge ref_clk);
    gpio_in <= 5'h00;
    repeat (PER + 5) @(posedge ref_clk);
    read_pin(8'h00, 8'h02, 8'h00, 8'h0A);
    $display("edges done");
    send(CMD_STORE_BOOT, LEN_ZERO, 8'h00, 8'h00, 8'h00, 1'b1);
    cmp("stored cfg", 8'h0A, {4'h0, boot_image.cfg[0]});
    b = boot_image;
    b.level[3] = 7'h4D;
    b.cfg[9] = 4'hD;
    @(posedge ref_clk);
    boot_image_in <= b;
    boot_restore <= 1'b1;
    @(posedge ref_clk);
    boot_restore <= 1'b0;
    read_pin(8'h03, 8'h00, 8'h4D, {4'h0, CFG_RESET[3]});
    read_pin(8'h09, 8'h00, 8'h00, 8'h05);
    $display("boot state done");
    test_done();
  end
endmodule // gpio_pwm_command_port_test
`default_nettype wire

// file: test/host_model.sv
// Purpose: Host side issuing command packets
// Assumes: reply registered on the taking edge
// Notes: bus scrambled between packets
`timescale 1ns/10ps
`default_nettype none
module host_model
  import gpio_pwm_pkg::*;
(
  input wire logic ref_clk,
  output var logic cmd_valid,
  output var gpio_pwm_pkg::cmd_t cmd,
  input wire gpio_pwm_pkg::reply_t reply,
  input wire logic reply_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // ==========================================================
  // One packet per strobe, reply taken at its fixed slot
  task automatic xfer(input cmd_t c, output logic got, output reply_t r);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd <= ~c; // Stale packet must not look valid
    #1;
    got = reply_valid;
    r = reply;
  endtask
endmodule // host_model
`default_nettype wire
